// File: rtl/fsls_pkg.sv
package fsls_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int unsigned CLK_MHZ          = 125;
   localparam int unsigned FRAME_US         = 125;
   localparam int unsigned FRAME_CYCLES_DEF = FRAME_US * CLK_MHZ;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] ADDR_STATUS    = 8'h08;
   localparam logic [7:0] ADDR_FIFO_EN   = 8'h09;
   localparam logic [7:0] ADDR_SUBCH     = 8'h0A;
   localparam logic [7:0] ADDR_FIRST     = 8'h0B;
   localparam logic [7:0] ADDR_CHAN      = 8'h0C;
   localparam logic [7:0] ADDR_MODE      = 8'h0D;
   localparam logic [7:0] ADDR_NEXT      = 8'h0E;
   localparam logic [7:0] ADDR_INDEX     = 8'h0F;
   localparam logic [7:0] ADDR_FIFO_SEL  = 8'h10;
   localparam logic [7:0] ADDR_CH_MASK   = 8'h11;
   localparam logic [7:0] ADDR_FRAME_CNT = 8'h12;

   ////////////////////////////////////////////////////////////////////////////
   // field layout
   localparam logic [1:0] MODE_SEQ    = 2'h3;
   localparam int         MODE_HI     = 1;
   localparam int         FLD_DIR     = 0;
   localparam int         FLD_NUM_HI  = 4;
   localparam int         FLD_CH_HI   = 5;
   localparam int         FLD_IDX_HI  = 4;
   localparam int         FLD_EN_HI   = 2;
   localparam int         SEQ_END_BIT = 7;
   localparam int         ST_WALK     = 0;
   localparam int         ST_SEQ      = 1;
   localparam int         ST_OVR      = 2;
   localparam int         ST_IDX_LO   = 3;
   localparam int         ST_IDX_HI   = 7;

   ////////////////////////////////////////////////////////////////////////////
   // sizes and reset values
   localparam int         LIST_LEN   = 32;
   localparam logic [4:0] LAST_IDX   = 5'h1F;
   localparam logic [4:0] FIRST_IDX  = 5'h00;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam int         BUF_DEPTH  = 8;

   typedef enum logic [0:0] {
      FSLS_IDLE = 1'b0,
      FSLS_WALK = 1'b1
   } fsls_walk_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } fsls_reg_req_t;

   typedef struct packed {
      logic       fifo_dir;
      logic [3:0] fifo_num;
      logic       ch_dir;
      logic [4:0] ch_num;
      logic [4:0] list_idx;
   } fsls_slot_t;

   localparam int SLOT_W = $bits(fsls_slot_t);

endpackage

// File: rtl/fsls_fifo.sv
module fsls_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             clk_en_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
      logic                        out_valid;
      logic [WIDTH-1:0]            out_data;
   } fsls_fifo_state_t;

   fsls_fifo_state_t s_q;
   fsls_fifo_state_t s_d;
   logic             push;
   logic             load;

   ////////////////////////////////////////////////////////////////////////////
   // memory plus an output register that is refilled while drained
   always_comb
   begin
      s_d  = s_q;
      push = in_valid_in && (s_q.count != CNT_FULL);
      load = (s_q.count != '0) && (!s_q.out_valid || out_ready_in);
      if (push)
      begin
         s_d.mem[s_q.wr_ptr] = in_data_in;
         s_d.wr_ptr          = s_q.wr_ptr + 1'b1;
      end
      if (load)
      begin
         s_d.out_data  = s_q.mem[s_q.rd_ptr];
         s_d.out_valid = 1'b1;
         s_d.rd_ptr    = s_q.rd_ptr + 1'b1;
      end
      else if (out_ready_in)
      begin
         s_d.out_valid = 1'b0;
      end
      s_d.count = s_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         s_q <= '0;
      else if (clk_en_in)
         s_q <= s_d;
   end

   assign in_ready_out  = (s_q.count != CNT_FULL);
   assign out_valid_out = s_q.out_valid;
   assign out_data_out  = s_q.out_data;

endmodule

// File: rtl/fsls_frame_timer.sv
module fsls_frame_timer #(
   parameter int unsigned PERIOD = 15625
) (
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic clk_en_in,
   output logic      tick_out
);
   localparam int CW = $clog2(PERIOD + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(PERIOD - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } fsls_timer_state_t;

   fsls_timer_state_t s_q;
   fsls_timer_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // one pulse per frame period
   always_comb
   begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == CNT_LAST)
      begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         s_q <= '0;
      else if (clk_en_in)
         s_q <= s_d;
   end

   assign tick_out = s_q.tick;

endmodule

// File: rtl/fsls_scheduler.sv
// How it works
// R01: flow mode field value 11 in the mode register selects sequence mode.
// R02: in sequence mode a write to 0x0F loads the list index, not FIFO select.
// R03: the list holds 32 entries, each a FIFO with its connected channel.
// R04: end-of-sequence bit 1 stops the walk; 0 continues with the next entry.
// R05: index 0 uses the first-FIFO register; later ones the previous next-FIFO field.
// R06: the whole list is walked once per 125 us frame, ascending from index 0.
// R07: a transmit FIFO listed repeatedly sends one byte per entry in list order.
// R08: a receive FIFO listed repeatedly collects bytes in list order.
// R09: n entries with distinct channels give n times 8 kbyte/s.
// R10: the list index field accepts 0 to 31 and selects the addressed entry.
// R11: channel, next-FIFO and subchannel arrays follow the list index in sequence mode.
// R12: software loads FIFO select with the channel before using the channel mask.
// R13: software writes the index, the entry fields, then the FIFO arrays.
// R14: software enables each participating FIFO with a nonzero enable field.
// R15: a list with each FIFO and channel once moves data like channel select mode.
// R16: in channel select mode each used channel needs an enabled FIFO.
// R17: in channel select mode each used PCM slot needs its own channel.
// R18: without an end bit the walk stops after index 31 and restarts next frame.
//
// The plain strobed port is this design's own decision.
module fsls_scheduler #(
   parameter int unsigned FRAME_CYCLES = fsls_pkg::FRAME_CYCLES_DEF
) (
   input  wire logic                   sys_clk_in,
   input  wire logic                   reset_in,
   input  wire logic                   clk_en_in,
   input  wire fsls_pkg::fsls_reg_req_t reg_req_in,
   output logic [7:0]                  reg_rdata_out,
   output logic                        slot_valid_out,
   output fsls_pkg::fsls_slot_t        slot_out,
   input  wire logic                   slot_ready_in,
   output logic                        frame_start_out,
   output logic                        seq_mode_out
);
   import fsls_pkg::*;

   typedef struct packed {
      logic [MODE_HI:0]                 mode;
      logic [FLD_IDX_HI:0]              list_idx;
      logic [FLD_NUM_HI:0]              fifo_sel;
      logic [7:0]                       first_fifo;
      logic [LIST_LEN-1:0][7:0]         chan;
      logic [LIST_LEN-1:0][7:0]         next;
      logic [LIST_LEN-1:0][7:0]         subch;
      logic [LIST_LEN-1:0][FLD_EN_HI:0] fifo_en;
      logic [LIST_LEN-1:0][7:0]         ch_mask;
      fsls_walk_t                       walk;
      logic [FLD_IDX_HI:0]              idx;
      logic [FLD_NUM_HI:0]              cur_fifo;
      logic                             overrun;
      logic [7:0]                       frame_cnt;
      logic [7:0]                       rdata;
      logic                             frame;
      logic                             seq;
   } fsls_top_state_t;

   fsls_top_state_t     s_q;
   fsls_top_state_t     s_d;
   logic                seq_mode;
   logic [FLD_IDX_HI:0] arr_idx;
   logic [FLD_NUM_HI:0] fid;
   logic                last_entry;
   logic                tick;
   logic                buf_ready;
   logic                push_valid;
   fsls_slot_t          push_slot;

   ////////////////////////////////////////////////////////////////////////////
   // frame pacing
   fsls_frame_timer #(
      .PERIOD (FRAME_CYCLES)
   ) u_timer (
      .clk_in    (sys_clk_in),
      .reset_in  (reset_in),
      .clk_en_in (clk_en_in),
      .tick_out  (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // slot buffer toward the channel assigner
   fsls_fifo #(
      .WIDTH (SLOT_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk_in        (sys_clk_in),
      .reset_in      (reset_in),
      .clk_en_in     (clk_en_in),
      .in_valid_in   (push_valid),
      .in_data_in    (push_slot),
      .in_ready_out  (buf_ready),
      .out_valid_out (slot_valid_out),
      .out_data_out  (slot_out),
      .out_ready_in  (slot_ready_in)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      s_d        = s_q;
      seq_mode   = (s_q.mode == MODE_SEQ);                                // [R01]
      // entry arrays follow the list index only in sequence mode
      arr_idx    = seq_mode ? s_q.list_idx : s_q.fifo_sel;                 // [R11]
      // in sequence mode the FIFO comes from the list, otherwise from the index
      fid        = seq_mode ? s_q.cur_fifo : s_q.idx;
      last_entry = 1'b0;
      push_valid = 1'b0;
      push_slot  = '0;
      s_d.frame  = tick;
      s_d.seq    = seq_mode;
      s_d.rdata  = RST_BYTE;

      /////////////////////////////////////////////////////////////////////////
      // register writes
      if (reg_req_in.wr)
      begin
         case (reg_req_in.addr)
            ADDR_MODE:
               s_d.mode = reg_req_in.wdata[MODE_HI:0];
            ADDR_INDEX:
            begin
               if (seq_mode)
                  s_d.list_idx = reg_req_in.wdata[FLD_IDX_HI:0];          // [R02] [R10]
               else
                  s_d.fifo_sel = reg_req_in.wdata[FLD_NUM_HI:0];
            end
            ADDR_FIFO_SEL:
               s_d.fifo_sel = reg_req_in.wdata[FLD_NUM_HI:0];
            ADDR_FIRST:
               s_d.first_fifo = reg_req_in.wdata;
            ADDR_CHAN:
               s_d.chan[arr_idx] = reg_req_in.wdata;                       // [R03] [R11]
            ADDR_NEXT:
               s_d.next[arr_idx] = reg_req_in.wdata;                       // [R11]
            ADDR_SUBCH:
               s_d.subch[arr_idx] = reg_req_in.wdata;                      // [R11]
            ADDR_FIFO_EN:
               s_d.fifo_en[s_q.fifo_sel] = reg_req_in.wdata[FLD_EN_HI:0];  // [R14]
            ADDR_CH_MASK:
               s_d.ch_mask[s_q.fifo_sel] = reg_req_in.wdata;
            default:
               s_d.mode = s_q.mode;
         endcase
      end

      /////////////////////////////////////////////////////////////////////////
      // register reads, data valid in the following cycle only
      if (reg_req_in.rd)
      begin
         case (reg_req_in.addr)
            ADDR_MODE:
               s_d.rdata = {{(7-MODE_HI){1'b0}}, s_q.mode};
            ADDR_FIFO_SEL:
               s_d.rdata = {{(7-FLD_NUM_HI){1'b0}}, s_q.fifo_sel};
            ADDR_FIRST:
               s_d.rdata = s_q.first_fifo;
            ADDR_CHAN:
               s_d.rdata = s_q.chan[arr_idx];
            ADDR_NEXT:
               s_d.rdata = s_q.next[arr_idx];
            ADDR_SUBCH:
               s_d.rdata = s_q.subch[arr_idx];
            ADDR_FIFO_EN:
               s_d.rdata = {{(7-FLD_EN_HI){1'b0}}, s_q.fifo_en[s_q.fifo_sel]};
            ADDR_CH_MASK:
               s_d.rdata = s_q.ch_mask[s_q.fifo_sel];
            ADDR_FRAME_CNT:
               s_d.rdata = s_q.frame_cnt;
            ADDR_STATUS:
            begin
               s_d.rdata[ST_WALK]             = (s_q.walk == FSLS_WALK);
               s_d.rdata[ST_SEQ]              = seq_mode;
               s_d.rdata[ST_OVR]              = s_q.overrun;
               s_d.rdata[ST_IDX_HI:ST_IDX_LO] = s_q.idx;
               // reading status clears the overrun flag
               s_d.overrun                    = 1'b0;
            end
            default:
               s_d.rdata = RST_BYTE;
         endcase
      end

      /////////////////////////////////////////////////////////////////////////
      // list walk
      case (s_q.walk)
         FSLS_IDLE:
         begin
            if (tick)
            begin
               s_d.walk      = FSLS_WALK;                                  // [R06]
               s_d.idx       = FIRST_IDX;                                  // [R06]
               s_d.cur_fifo  = s_q.first_fifo[FLD_NUM_HI:FLD_DIR];         // [R05]
               s_d.frame_cnt = s_q.frame_cnt + 1'b1;
            end
         end
         FSLS_WALK:
         begin
            // a new frame before the walk ended is flagged, set wins over clear
            if (tick)
               s_d.overrun = 1'b1;
            // a full buffer stalls the walk so no slot is dropped
            if (buf_ready)
            begin
               // disabled FIFOs keep their list place but move nothing
               push_valid         = (s_q.fifo_en[fid] != '0);             // [R14]
               push_slot.fifo_dir = fid[FLD_DIR];                          // [R07] [R08]
               push_slot.fifo_num = fid[FLD_NUM_HI:FLD_DIR+1];             // [R07] [R08]
               push_slot.ch_dir   = s_q.chan[s_q.idx][FLD_DIR];            // [R03] [R09]
               push_slot.ch_num   = s_q.chan[s_q.idx][FLD_CH_HI:FLD_DIR+1]; // [R09] [R15]
               push_slot.list_idx = s_q.idx;
               last_entry = (s_q.idx == LAST_IDX)                          // [R18]
                            || (seq_mode && s_q.next[s_q.idx][SEQ_END_BIT]); // [R04]
               if (last_entry)
               begin
                  s_d.walk = FSLS_IDLE;                                    // [R04] [R18]
               end
               else
               begin
                  s_d.idx      = s_q.idx + 1'b1;                           // [R06]
                  s_d.cur_fifo = s_q.next[s_q.idx][FLD_NUM_HI:FLD_DIR];    // [R05]
               end
            end
         end
         default:
            s_d.walk = FSLS_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
         s_q <= '0;
      else if (clk_en_in)
         s_q <= s_d;
   end

   assign reg_rdata_out   = s_q.rdata;
   assign frame_start_out = s_q.frame;
   assign seq_mode_out    = s_q.seq;

endmodule

// File: verif/fsls_scheduler_asserts.sv
module fsls_scheduler_asserts #(
   parameter int unsigned FRAME_CYCLES = fsls_pkg::FRAME_CYCLES_DEF
) (
   input wire logic                    sys_clk_in,
   input wire logic                    reset_in,
   input wire logic                    clk_en_in,
   input wire fsls_pkg::fsls_reg_req_t reg_req_in,
   input wire logic [7:0]              reg_rdata_out,
   input wire logic                    slot_valid_out,
   input wire fsls_pkg::fsls_slot_t    slot_out,
   input wire logic                    slot_ready_in,
   input wire logic                    frame_start_out,
   input wire logic                    seq_mode_out
);
   import fsls_pkg::*;
   logic [7:0] nxt_q [32];
   logic [7:0] chn_q [32];
   logic [7:0] first_q;
   logic [4:0] idx_q;
   logic [4:0] last_q;
   logic       fresh_q;
   logic       end_q;
   logic       wr_ok;
   logic       take;
   assign wr_ok = clk_en_in && reg_req_in.wr;
   assign take = clk_en_in && slot_valid_out && slot_ready_in;
   // shadow of the list as written, and progress of the current walk
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         nxt_q <= '{default: 8'h00};
         chn_q <= '{default: 8'h00};
         first_q <= 8'h00;
         idx_q <= 5'h00;
         last_q <= 5'h00;
         fresh_q <= 1'b1;
         end_q <= 1'b0;
      end
      else if (clk_en_in)
      begin
         if (wr_ok && reg_req_in.addr == ADDR_FIRST)
            first_q <= reg_req_in.wdata;
         if (wr_ok && seq_mode_out && reg_req_in.addr == ADDR_INDEX)
            idx_q <= reg_req_in.wdata[4:0];
         if (wr_ok && seq_mode_out && reg_req_in.addr == ADDR_NEXT)
            nxt_q[idx_q] <= reg_req_in.wdata;
         if (wr_ok && seq_mode_out && reg_req_in.addr == ADDR_CHAN)
            chn_q[idx_q] <= reg_req_in.wdata;
         if (take)
         begin
            fresh_q <= 1'b0;
            last_q <= slot_out.list_idx;
            end_q <= nxt_q[slot_out.list_idx][SEQ_END_BIT];
         end
         if (frame_start_out)
         begin
            fresh_q <= 1'b1;
            end_q <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   sequence s_mode_on;
      wr_ok && reg_req_in.addr == ADDR_MODE && reg_req_in.wdata[MODE_HI:0] == MODE_SEQ
         ##1 clk_en_in;
   endsequence
   sequence s_seq_take;
      take && seq_mode_out;
   endsequence
   chk_mode_enter: assert property (s_mode_on |=> seq_mode_out)
      else $error("sequence mode flag not set");
   chk_index_wo: assert property (clk_en_in && reg_req_in.rd &&
      reg_req_in.addr == ADDR_INDEX |=> reg_rdata_out == 8'h00) else $error("index read not 0");
   chk_frame_pulse: assert property (frame_start_out && clk_en_in |=> !frame_start_out)
      else $error("frame start longer than one cycle");
   chk_slot_hold: assert property (slot_valid_out && !slot_ready_in && clk_en_in
      |=> slot_valid_out && $stable(slot_out)) else $error("slot dropped before taken");
   chk_idx_up: assert property (take |-> fresh_q || slot_out.list_idx > last_q)
      else $error("list index not ascending");
   chk_first_src: assert property (s_seq_take ##0 slot_out.list_idx == FIRST_IDX
      |-> {slot_out.fifo_num, slot_out.fifo_dir} == first_q[4:0]) else $error("bad first fifo");
   chk_next_src: assert property (s_seq_take ##0 slot_out.list_idx != FIRST_IDX
      |-> {slot_out.fifo_num, slot_out.fifo_dir} == nxt_q[slot_out.list_idx - 5'h01][4:0])
      else $error("bad next fifo");
   chk_chan_map: assert property (s_seq_take
      |-> {slot_out.ch_num, slot_out.ch_dir} == chn_q[slot_out.list_idx][5:0])
      else $error("bad channel for entry");
   chk_end_stop: assert property (s_seq_take |-> fresh_q || !end_q)
      else $error("slot after end of list");
endmodule
bind fsls_scheduler fsls_scheduler_asserts #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
   .sys_clk_in(sys_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
   .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .slot_valid_out(slot_valid_out),
   .slot_out(slot_out), .slot_ready_in(slot_ready_in), .frame_start_out(frame_start_out),
   .seq_mode_out(seq_mode_out));

// File: verif/fsls_slot_sink.sv
module fsls_slot_sink (
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   input  wire logic slow_in,
   input  wire logic slot_valid_in,
   output logic      slot_ready_out
);
   // slow mode accepts about one slot in three
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
         slot_ready_out <= 1'b0;
      else
         slot_ready_out <= !slow_in || !slot_valid_in || ($urandom % 3 == 0);
   end
endmodule

// File: verif/test_fifo_sequence_list_scheduler.sv
module test_fifo_sequence_list_scheduler;
   timeunit 1ns;
   timeprecision 1ps;
   import fsls_pkg::*;
   localparam int unsigned FC = 400;
   logic          sys_clk_in;
   logic          reset_in;
   logic          en;
   bit            channel_select_mode;
   logic          slow;
   fsls_reg_req_t req;
   logic [7:0]    rdata;
   logic          valid;
   logic          ready;
   logic          fstart;
   logic          seqm;
   fsls_slot_t    slot;
   fsls_slot_t    got [$];
   logic [7:0]    nxt [32];
   logic [7:0]    chn [32];
   logic [7:0]    first;
   int            failures;
   int            tests_run;
   fsls_scheduler #(.FRAME_CYCLES(FC)) u_dut (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .clk_en_in(en), .reg_req_in(req),
      .reg_rdata_out(rdata), .slot_valid_out(valid), .slot_out(slot), .slot_ready_in(ready),
      .frame_start_out(fstart), .seq_mode_out(seqm));
   fsls_slot_sink u_sink (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .slow_in(slow),
      .slot_valid_in(valid), .slot_ready_out(ready));
   initial
   begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in)
      if (valid && ready && en)
         got.push_back(slot);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_slot(string nm, fsls_slot_t e, fsls_slot_t g);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge sys_clk_in);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_in);
      req.wr <= 1'b0;
   endtask
   task automatic rd_chk(string nm, logic [7:0] a, logic [7:0] e);
      @(posedge sys_clk_in);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_in);
      req.rd <= 1'b0;
      #1 chk_byte(nm, e, rdata);
   endtask
   task automatic wait_frame();
      int n;
      n = 0;
      @(posedge sys_clk_in);
      while (fstart !== 1'b1 && n < 2 * FC)
      begin
         @(posedge sys_clk_in);
         n++;
      end
      chk_byte("frame start", 8'h01, {7'h0, fstart});
   endtask
   function automatic fsls_slot_t exp_slot(int i);
      logic [7:0] f;
      // in channel select mode the FIFO id is the walk index itself
      f = channel_select_mode ? 8'(i) : (i == 0) ? first : nxt[i - 1];
      return '{fifo_dir: f[0], fifo_num: f[4:1], ch_dir: chn[i][0], ch_num: chn[i][5:1],
               list_idx: 5'(i)};
   endfunction
   // program early in a frame so the next walk sees a whole list
   task automatic load_list(int n, bit use_end);
      slow <= 1'b0;
      wait_frame();
      repeat (60) @(posedge sys_clk_in);
      first = {3'h0, 4'($urandom % 4), 1'($urandom)};
      wr(ADDR_FIRST, first);
      for (int i = 0; i < n; i++)
      begin
         chn[i] = {2'h0, 5'($urandom), 1'($urandom)};
         nxt[i] = {use_end && i == n - 1, 2'h0, 4'($urandom % 4), 1'($urandom)};
         wr(ADDR_INDEX, 8'(i));
         wr(ADDR_CHAN, chn[i]);
         wr(ADDR_SUBCH, 8'h00);
         wr(ADDR_NEXT, nxt[i]);
      end
   endtask
   task automatic check_frames(int n, bit s);
      slow <= s;
      wait_frame();
      repeat (2)
      begin
         got.delete();
         wait_frame();
         chk_byte("slot count", 8'(n), 8'(got.size()));
         for (int i = 0; i < n && i < got.size(); i++)
            chk_slot("slot", exp_slot(i), got[i]);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(FC * 8 * 50);
      chk_byte("watchdog", 8'h00, 8'h01);
      final_report();
   end
   initial
   begin
      int n;
      int k;
      reset_in = 1'b1;
      slow = 1'b0;
      en = 1'b1;
      channel_select_mode = 1'b0;
      req = '0;
      failures = 0;
      tests_run = 0;
      void'($urandom(32'h60d23e99));
      repeat (2) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      @(posedge sys_clk_in);
      #1 chk_byte("reset outputs", 8'h00, {4'h0, valid, fstart, seqm, |rdata});
      rd_chk("index read", ADDR_INDEX, 8'h00);
      rd_chk("unmapped read", 8'h3F, 8'h00);
      for (int m = 0; m < 4; m++)
      begin
         wr(ADDR_MODE, 8'(m));
         rd_chk("mode", ADDR_MODE, 8'(m));
         chk_byte("seq flag", {7'h0, m == 3}, {7'h0, seqm});
      end
      $display("test registers done");
      for (int i = 0; i < 8; i++)
      begin
         wr(ADDR_FIFO_SEL, 8'(i));
         wr(ADDR_FIFO_EN, 8'h07);
      end
      for (int t = 0; t < 4; t++)
      begin
         n = (t == 0) ? 1 : 2 + $urandom % 11;
         load_list(n, 1'b1);
         k = $urandom % n;
         wr(ADDR_INDEX, 8'(k));
         rd_chk("channel entry", ADDR_CHAN, chn[k]);
         rd_chk("next entry", ADDR_NEXT, nxt[k]);
         check_frames(n, t[0]);
         $display("test list of %0d entries done", n);
      end
      load_list(32, 1'b0);
      check_frames(32, 1'b1);
      $display("test full list done");
      channel_select_mode = 1'b1;
      slow <= 1'b0;
      wait_frame();
      repeat (60) @(posedge sys_clk_in);
      wr(ADDR_MODE, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         // one distinct channel per used FIFO, same direction as the FIFO
         chn[i] = {2'h0, 5'(i * 4 + $urandom % 4), 1'(i)};
         wr(ADDR_FIFO_SEL, 8'(i));
         wr(ADDR_CHAN, chn[i]);
      end
      wr(ADDR_FIFO_SEL, chn[3]);
      wr(ADDR_CH_MASK, 8'h5A);
      rd_chk("channel mask", ADDR_CH_MASK, 8'h5A);
      check_frames(8, 1'b0);
      $display("test channel select done");
      // frozen for two frame periods: no frame start may appear
      en <= 1'b0;
      n = 0;
      repeat (2 * FC)
      begin
         @(posedge sys_clk_in);
         if (fstart === 1'b1)
            n++;
      end
      en <= 1'b1;
      chk_byte("frozen frame starts", 8'h00, 8'(n));
      wait_frame();
      $display("test clock enable done");
      final_report();
   end
endmodule
